// file: inc/dio_params.svh
// Constants for the drive digital I/O objects: object indices, field positions, reset values.
// Assumes inclusion by bare name from the design files.
//
// Contract
// [R01] Overtravel and home switches in bits 0-2, on=1
// [R02] Terminal inputs bits 16-20, inverted sense
// [R03] Remote-allocated inputs passed on, not acted on
// [R04] Level bit acts only when mask bit set
// [R05] Bits 16-19 drive general-purpose outputs when masked
// [R06] Optional inversion per general-purpose output
// [R07] Bus outputs also need bus-output enable settings
// [R08] Bits 24-27 routed to remote outputs
// [R09] Bits 16-20, 24, 25 are active-low
// [R10] Reserved bits read zero, writes ignored
// [R11] Both output words reset to zero
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

`define DIO_IDX_INPUTS     16'h60FD
`define DIO_IDX_OUTPUTS    16'h60FE
`define DIO_SUB_COUNT      8'h00
`define DIO_SUB_LEVEL      8'h01
`define DIO_SUB_MASK       8'h02
`define DIO_ENTRY_COUNT    32'h0000_0002
`define DIO_LEVEL_RESET    32'h0000_0000
`define DIO_MASK_RESET     32'h0000_0000
`define DIO_OUT_WMASK      32'h0F1F_0000
`define DIO_IN_NOT_BIT     0
`define DIO_IN_POS_BIT     1
`define DIO_IN_HOME_BIT    2
`define DIO_TERM_BIT       16
`define DIO_REMOTE_BIT     24
`define DIO_RST_STAGES     2

`endif

// file: inc/dio_pkg.sv
// Types shared by the digital I/O object block.
// Assumes dio_params.svh is on the include path.
package dio_pkg;
    typedef enum logic [1:0] {
        DIO_ANS_OK,
        DIO_ANS_NO_OBJECT,
        DIO_ANS_NO_SUBINDEX,
        DIO_ANS_READ_ONLY
    } dio_answer_e;

    typedef logic [31:0] dio_word_t;
endpackage

// file: inc/dio_if.sv
// Carrier between the top and its two mapping modules.
// Assumes a single clock domain; all members are plain levels.
`timescale 1ns/100ps
`default_nettype none
interface dio_map_if;
    import dio_pkg::*;
    dio_word_t   level_word;
    dio_word_t   enable_mask;
    logic [4:0]  in_remote;
    logic [7:0]  gp_select;
    logic [3:0]  gp_bus_enable;
    logic [3:0]  gp_invert;
    logic [3:0]  rem_select;
    logic [1:0]  rem_bus_enable;
    logic [3:0]  gp_drive;
    logic [1:0]  rem_drive;

    modport ctrl (
        output level_word,
        output enable_mask,
        output in_remote,
        output gp_select,
        output gp_bus_enable,
        output gp_invert,
        output rem_select,
        output rem_bus_enable,
        input  gp_drive,
        input  rem_drive
    );
    modport outmap (
        input  level_word,
        input  enable_mask,
        input  gp_select,
        input  gp_bus_enable,
        input  gp_invert,
        input  rem_select,
        input  rem_bus_enable,
        output gp_drive,
        output rem_drive
    );
endinterface
`default_nettype wire

// file: logic/dio_in_map.sv
// Builds the digital input word from the switch and terminal pins.
// Assumes pins are synchronous and active high (1 = switched on / active).
`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"
module dio_in_map
    import dio_pkg::*;
#(
    parameter int N_TERM = 5
) (
    input  wire logic              neg_overtravel_switch,
    input  wire logic              positive_overtravel_switch,
    input  wire logic              home_switch,
    input  wire logic [N_TERM-1:0] terminal_io_in,
    input  wire logic [N_TERM-1:0] in_remote,
    output var  dio_word_t         input_word,
    output logic [N_TERM-1:0]      local_active
);
    initial begin
        if (N_TERM < 1 || N_TERM > 8) begin
            $error("dio_in_map: N_TERM out of range");
        end
    end

    always_comb begin
        input_word = 32'h0000_0000;                                // [R10]
        input_word[`DIO_IN_NOT_BIT]  = neg_overtravel_switch;      // [R01]
        input_word[`DIO_IN_POS_BIT]  = positive_overtravel_switch; // [R01]
        input_word[`DIO_IN_HOME_BIT] = home_switch;                // [R01]
        for (int i = 0; i < N_TERM; i++) begin
            input_word[`DIO_TERM_BIT + i] = ~terminal_io_in[i];    // [R02]
        end
    end

    // Remote inputs are reported only; the drive itself never sees them
    genvar g;
    generate
        for (g = 0; g < N_TERM; g++) begin : g_local
            assign local_active[g] = terminal_io_in[g] & ~in_remote[g]; // [R03]
        end
    endgenerate
endmodule
`default_nettype wire

// file: logic/dio_out_map.sv
// Routes the output level word onto the general-purpose and remote outputs.
// Assumes the level and mask words already hold only writable bits.
`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"
module dio_out_map
    import dio_pkg::*;
(
    dio_map_if.outmap m
);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gp
            logic [1:0] sel;
            logic       lvl;
            logic       act;
            assign sel = m.gp_select[2*g +: 2];
            assign lvl = m.level_word[`DIO_TERM_BIT + sel];         // [R05]
            // Active-low level; needs mask bit and bus enable as well
            assign act = ~lvl & m.enable_mask[`DIO_TERM_BIT + sel]  // [R04] [R09]
                       & m.gp_bus_enable[g];                        // [R07]
            assign m.gp_drive[g] = act ^ m.gp_invert[g];            // [R06]
        end
        for (g = 0; g < 2; g++) begin : g_rem
            logic [1:0] sel;
            logic       lvl;
            assign sel = m.rem_select[2*g +: 2];
            // Bits 24 and 25 are active-low, 26 and 27 active-high
            assign lvl = (sel < 2'd2) ? ~m.level_word[`DIO_REMOTE_BIT + sel]  // [R09]
                                      : m.level_word[`DIO_REMOTE_BIT + sel];  // [R08]
            assign m.rem_drive[g] = lvl & m.enable_mask[`DIO_REMOTE_BIT + sel] // [R04]
                                  & m.rem_bus_enable[g];                       // [R07]
        end
    endgenerate
endmodule
`default_nettype wire

// file: logic/dio_top.sv
// Digital input and output objects of the drive, reached by object index and subindex.
// Assumes one 100 MHz clock, synchronous pins and one request at a time from the master.
`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"
module dio_top
    import dio_pkg::*;
#(
    parameter int N_TERM_IN = 5
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Object access from the field-bus side
    input  wire logic        obj_req,
    input  wire logic        obj_wr,
    input  wire logic [15:0] obj_index,
    input  wire logic [7:0]  obj_subindex,
    input  wire logic [31:0] obj_wdata,
    output logic             obj_ack,
    output var  dio_answer_e obj_answer,
    output logic [31:0]      obj_rdata,
    // Switch and terminal inputs
    input  wire logic        neg_overtravel_switch,
    input  wire logic        positive_overtravel_switch,
    input  wire logic        home_switch,
    input  wire logic [4:0]  terminal_io_in,
    // Allocation, enable and inversion settings
    input  wire logic [4:0]  io_allocation_setting_low,
    input  wire logic [7:0]  io_allocation_setting_high,
    input  wire logic [3:0]  remote_output_allocation,
    input  wire logic [3:0]  bus_output_enable_low,
    input  wire logic [1:0]  bus_output_enable_high,
    input  wire logic [3:0]  output_inversion_low,
    // Drive-side results
    output logic [4:0]       local_input_active,
    output logic [4:0]       remote_input_state,
    output logic [3:0]       gp_output_drive,
    output logic [1:0]       remote_output_a_b
);
    // ==========================================================================
    // Elaboration checks
    initial begin
        if (N_TERM_IN != 5) begin
            $error("dio_top: terminal input count must be 5");
        end
    end

    // ==========================================================================
    // Reset release
    logic [`DIO_RST_STAGES-1:0] rst_sync_r;
    logic                       rst_int_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[`DIO_RST_STAGES-2:0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_r[`DIO_RST_STAGES-1];

    // ==========================================================================
    // Output words
    dio_word_t level_word_r;
    dio_word_t level_word_nxt;
    dio_word_t enable_mask_r;
    dio_word_t enable_mask_nxt;
    logic      hit_outputs;
    logic      hit_inputs;
    logic      wr_level;
    logic      wr_mask;

    assign hit_inputs  = obj_index == `DIO_IDX_INPUTS;
    assign hit_outputs = obj_index == `DIO_IDX_OUTPUTS;
    assign wr_level    = obj_req & obj_wr & hit_outputs & (obj_subindex == `DIO_SUB_LEVEL);
    assign wr_mask     = obj_req & obj_wr & hit_outputs & (obj_subindex == `DIO_SUB_MASK);

    // Reserved bits are dropped at the write so they always read back zero
    always_comb begin
        level_word_nxt = level_word_r;
        if (wr_level) begin
            level_word_nxt = obj_wdata & `DIO_OUT_WMASK; // [R10]
        end
    end

    always_comb begin
        enable_mask_nxt = enable_mask_r;
        if (wr_mask) begin
            enable_mask_nxt = obj_wdata & `DIO_OUT_WMASK; // [R10]
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            level_word_r <= `DIO_LEVEL_RESET; // [R11]
        end else begin
            level_word_r <= level_word_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            enable_mask_r <= `DIO_MASK_RESET; // [R11]
        end else begin
            enable_mask_r <= enable_mask_nxt;
        end
    end

    // ==========================================================================
    // Input mapping
    dio_word_t  input_word;
    logic [4:0] local_active;

    // Settings travel to both mapping modules through the one carrier
    dio_map_if map_if ();

    dio_in_map #(
        .N_TERM (N_TERM_IN)
    ) u_in_map (
        .neg_overtravel_switch      (neg_overtravel_switch),
        .positive_overtravel_switch (positive_overtravel_switch),
        .home_switch                (home_switch),
        .terminal_io_in             (terminal_io_in),
        .in_remote                  (map_if.in_remote),
        .input_word                 (input_word),
        .local_active               (local_active)
    );

    // Registered snapshot gives the master a stable word one cycle behind the pins
    dio_word_t input_word_r;

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            input_word_r <= 32'h0000_0000;
        end else begin
            input_word_r <= input_word; // [R01] [R02]
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            local_input_active <= 5'h00;
            remote_input_state <= 5'h00;
        end else begin
            local_input_active <= local_active;                                  // [R03]
            remote_input_state <= terminal_io_in & io_allocation_setting_low;    // [R03]
        end
    end

    // ==========================================================================
    // Output mapping
    assign map_if.level_word     = level_word_r;
    assign map_if.enable_mask    = enable_mask_r;
    assign map_if.in_remote      = io_allocation_setting_low;
    assign map_if.gp_select      = io_allocation_setting_high;
    assign map_if.gp_bus_enable  = bus_output_enable_low;
    assign map_if.gp_invert      = output_inversion_low;
    assign map_if.rem_select     = remote_output_allocation;
    assign map_if.rem_bus_enable = bus_output_enable_high;

    dio_out_map u_out_map (
        .m (map_if.outmap)
    );

    // Terminal drive is registered so no routing glitch reaches a pin
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            gp_output_drive <= 4'h0;
        end else begin
            gp_output_drive <= map_if.gp_drive; // [R05] [R06]
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            remote_output_a_b <= 2'h0;
        end else begin
            remote_output_a_b <= map_if.rem_drive; // [R08]
        end
    end

    // ==========================================================================
    // Object answers
    dio_answer_e answer_nxt;
    dio_word_t   rdata_nxt;

    always_comb begin
        answer_nxt = DIO_ANS_OK;
        rdata_nxt  = 32'h0000_0000;
        if (hit_inputs) begin
            if (obj_subindex != `DIO_SUB_COUNT) begin
                answer_nxt = DIO_ANS_NO_SUBINDEX;
            end else if (obj_wr) begin
                answer_nxt = DIO_ANS_READ_ONLY;
            end else begin
                rdata_nxt = input_word_r; // [R10]
            end
        end else if (hit_outputs) begin
            unique case (obj_subindex)
                `DIO_SUB_COUNT: begin
                    if (obj_wr) begin
                        answer_nxt = DIO_ANS_READ_ONLY;
                    end else begin
                        rdata_nxt = `DIO_ENTRY_COUNT;
                    end
                end
                `DIO_SUB_LEVEL: begin
                    rdata_nxt = obj_wr ? 32'h0000_0000 : level_word_r; // [R04]
                end
                `DIO_SUB_MASK: begin
                    rdata_nxt = obj_wr ? 32'h0000_0000 : enable_mask_r; // [R04]
                end
                default: begin
                    answer_nxt = DIO_ANS_NO_SUBINDEX;
                end
            endcase
        end else begin
            answer_nxt = DIO_ANS_NO_OBJECT;
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            obj_ack <= 1'b0;
        end else begin
            obj_ack <= obj_req;
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            obj_answer <= DIO_ANS_OK;
            obj_rdata  <= 32'h0000_0000;
        end else if (obj_req) begin
            obj_answer <= answer_nxt;
            obj_rdata  <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// file: testbench/dio_pins_model.sv
// Terminal-block side model: switch and terminal input pins.
// Assumes one clock; the pins change only just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module dio_pins_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_cmd,
    output logic      [2:0] sw,
    output logic      [4:0] term
);
    // =====
    // Pins
    // Registered, because the drive takes these pins as synchronous
    always_ff @(posedge core_clk) begin
        sw <= pin_cmd[2:0];
        term <= pin_cmd[7:3];
    end
endmodule
`default_nettype wire

// file: testbench/dio_top_asserts.sv
// Checker for the digital I/O object block, bound to its top.
// Assumes the top releases reset through two stages.
`timescale 1ns/100ps
`default_nettype none
module dio_top_asserts
    import dio_pkg::*;
#(
    parameter int N_TERM_IN = 5
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        obj_req,
    input wire logic        obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [7:0]  obj_subindex,
    input wire logic        obj_ack,
    input wire dio_answer_e obj_answer,
    input wire logic [31:0] obj_rdata,
    input wire logic        neg_overtravel_switch,
    input wire logic        positive_overtravel_switch,
    input wire logic        home_switch,
    input wire logic [4:0]  terminal_io_in,
    input wire logic [4:0]  io_allocation_setting_low,
    input wire logic [3:0]  bus_output_enable_low,
    input wire logic [1:0]  bus_output_enable_high,
    input wire logic [3:0]  output_inversion_low,
    input wire logic [4:0]  local_input_active,
    input wire logic [4:0]  remote_input_state,
    input wire logic [3:0]  gp_output_drive,
    input wire logic [1:0]  remote_output_a_b
);
    // =====
    // Helpers
    logic [1:0] up_r;
    logic [2:0] sw_w;
    logic       rd_in;
    logic       wr_out;
    assign sw_w = {home_switch, positive_overtravel_switch, neg_overtravel_switch};
    assign rd_in = obj_req && !obj_wr && obj_index == 16'h60FD && obj_subindex == 8'h00;
    assign wr_out = obj_req && obj_wr && obj_index == 16'h60FE && obj_subindex inside {8'h01, 8'h02};
    // Outputs sit at zero while the reset chain fills, so they are judged only after it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // =====
    // Properties
    property p_in_sw;
        rd_in |=> obj_ack && obj_rdata[2:0] == $past(sw_w, 2);
    endproperty
    a_in_sw: assert property (p_in_sw) else $error("switch bits wrong");
    property p_in_term;
        rd_in |=> obj_rdata[20:16] == ~$past(terminal_io_in, 2);
    endproperty
    a_in_term: assert property (p_in_term) else $error("terminal bits wrong");
    property p_in_rsvd;
        rd_in |=> obj_rdata[15:3] == 13'h0000 && obj_rdata[31:21] == 11'h000;
    endproperty
    a_in_rsvd: assert property (p_in_rsvd) else $error("reserved input bits set");
    property p_loc;
        up_r == 2'h3 |-> local_input_active == ($past(terminal_io_in) & ~$past(io_allocation_setting_low));
    endproperty
    a_loc: assert property (p_loc) else $error("local input wrong");
    property p_rin;
        up_r == 2'h3 |-> remote_input_state == ($past(terminal_io_in) & $past(io_allocation_setting_low));
    endproperty
    a_rin: assert property (p_rin) else $error("remote input wrong");
    property p_wr;
        wr_out |=> obj_ack && obj_answer == DIO_ANS_OK && obj_rdata == 32'h0000_0000;
    endproperty
    a_wr: assert property (p_wr) else $error("output word write refused");
    property p_gp_off;
        up_r == 2'h3 |-> ((gp_output_drive ^ $past(output_inversion_low)) & ~$past(bus_output_enable_low)) == 4'h0;
    endproperty
    a_gp_off: assert property (p_gp_off) else $error("gp output driven without bus enable");
    property p_rem_off;
        up_r == 2'h3 |-> (remote_output_a_b & ~$past(bus_output_enable_high)) == 2'h0;
    endproperty
    a_rem_off: assert property (p_rem_off) else $error("remote output driven without bus enable");
    c_rd: cover property (rd_in ##1 obj_ack);
    c_gp: cover property (gp_output_drive == 4'hF);
    c_rem: cover property (remote_output_a_b == 2'h3);
endmodule
bind dio_top dio_top_asserts #(.N_TERM_IN(N_TERM_IN)) i_dio_top_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_subindex(obj_subindex), .obj_ack(obj_ack), .obj_answer(obj_answer), .obj_rdata(obj_rdata),
    .neg_overtravel_switch(neg_overtravel_switch), .positive_overtravel_switch(positive_overtravel_switch),
    .home_switch(home_switch), .terminal_io_in(terminal_io_in),
    .io_allocation_setting_low(io_allocation_setting_low), .bus_output_enable_low(bus_output_enable_low),
    .bus_output_enable_high(bus_output_enable_high), .output_inversion_low(output_inversion_low),
    .local_input_active(local_input_active), .remote_input_state(remote_input_state),
    .gp_output_drive(gp_output_drive), .remote_output_a_b(remote_output_a_b)
);
`default_nettype wire

// file: testbench/drive_digital_io_objects_tb_top.sv
// Self-checking bench for the digital I/O object block.
// Assumes the checker binds itself and the pin model drives the terminal side.
`timescale 1ns/100ps
`default_nettype none
module drive_digital_io_objects_tb_top
    import dio_pkg::*;
;
    logic        core_clk, rst_n, obj_req, obj_wr, obj_ack;
    logic [15:0] obj_index;
    logic [7:0]  obj_subindex, pin_cmd, alloc_hi;
    logic [31:0] obj_wdata, obj_rdata;
    dio_answer_e obj_answer;
    logic [2:0]  sw;
    logic [4:0]  term, alloc_lo, loc_act, rem_in;
    logic [3:0]  rem_alloc, bus_lo, inv, gp_drv;
    logic [1:0]  bus_hi, rem_drv;
    int          n_errors, compares;
    dio_top i_dio_top (
        .core_clk(core_clk), .rst_n(rst_n), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_subindex(obj_subindex), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_answer(obj_answer),
        .obj_rdata(obj_rdata), .neg_overtravel_switch(sw[0]), .positive_overtravel_switch(sw[1]),
        .home_switch(sw[2]), .terminal_io_in(term), .io_allocation_setting_low(alloc_lo),
        .io_allocation_setting_high(alloc_hi), .remote_output_allocation(rem_alloc),
        .bus_output_enable_low(bus_lo), .bus_output_enable_high(bus_hi), .output_inversion_low(inv),
        .local_input_active(loc_act), .remote_input_state(rem_in), .gp_output_drive(gp_drv),
        .remote_output_a_b(rem_drv)
    );
    dio_pins_model i_dio_pins_model (.core_clk(core_clk), .pin_cmd(pin_cmd), .sw(sw), .term(term));
    // =====
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // Answer is registered on the taking edge itself, so no wait loop is needed
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
        @(posedge core_clk);
        obj_req <= 1'b1;
        obj_wr <= wr;
        obj_index <= idx;
        obj_subindex <= sub;
        obj_wdata <= wd;
        @(posedge core_clk);
        obj_req <= 1'b0;
        // Acknowledge stands for one cycle only, so it is looked at right after the taking edge
        #1;
        chk(obj_ack, 1'b1);
    endtask
    task automatic out_case(input logic [31:0] lvl, msk, input logic [7:0] al, input logic [3:0] bl, iv, ra,
                            input logic [1:0] bh, input logic [5:0] exp);
        @(posedge core_clk);
        alloc_hi <= al;
        bus_lo <= bl;
        inv <= iv;
        rem_alloc <= ra;
        bus_hi <= bh;
        acc(1'b1, 16'h60FE, 8'h01, lvl);
        acc(1'b1, 16'h60FE, 8'h02, msk);
        wt();
        chk({rem_drv, gp_drv}, exp);
    endtask
    task automatic finish_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // =====
    // Scenarios
    task automatic t_reset();
        acc(1'b0, 16'h60FE, 8'h01, 32'h0000_0000);
        chk(obj_rdata, 32'h0000_0000);
        acc(1'b0, 16'h60FE, 8'h02, 32'h0000_0000);
        chk(obj_rdata, 32'h0000_0000);
        acc(1'b0, 16'h60FE, 8'h00, 32'h0000_0000);
        chk(obj_rdata, 32'h0000_0002);
        chk(gp_drv, 4'h0);
        $display("test reset done");
    endtask
    task automatic t_inputs();
        logic [7:0] p;
        for (int i = 0; i < 3; i++) begin
            p = (i == 0) ? 8'h35 : (i == 1) ? 8'hCA : 8'hFF;
            @(posedge core_clk);
            pin_cmd <= p;
            wt();
            acc(1'b0, 16'h60FD, 8'h00, 32'h0000_0000);
            chk(obj_rdata[2:0], p[2:0]);
            chk(obj_rdata[20:16], 5'(~p[7:3]));
            chk({obj_rdata[31:21], obj_rdata[15:3]}, 24'h00_0000);
        end
        $display("test inputs done");
    endtask
    task automatic t_remote_in();
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            pin_cmd <= 8'h35;
            alloc_lo <= i ? 5'h1F : 5'h0A;
            wt();
            chk(loc_act, 5'h06 & ~alloc_lo);
            chk(rem_in, 5'h06 & alloc_lo);
        end
        $display("test remote inputs done");
    endtask
    task automatic t_access();
        acc(1'b1, 16'h60FE, 8'h01, 32'hFFFF_FFFF);
        acc(1'b1, 16'h60FE, 8'h02, 32'hFFFF_FFFF);
        acc(1'b1, 16'h60FD, 8'h00, 32'h0000_0001);
        chk(obj_answer, DIO_ANS_READ_ONLY);
        acc(1'b1, 16'h60FE, 8'h00, 32'h0000_0005);
        chk(obj_answer, DIO_ANS_READ_ONLY);
        acc(1'b0, 16'h6000, 8'h01, 32'h0000_0000);
        chk(obj_answer, DIO_ANS_NO_OBJECT);
        acc(1'b1, 16'h60FE, 8'h03, 32'h0000_0000);
        chk(obj_answer, DIO_ANS_NO_SUBINDEX);
        acc(1'b0, 16'h60FE, 8'h01, 32'h0000_0000);
        chk(obj_rdata, 32'h0F1F_0000);
        acc(1'b0, 16'h60FE, 8'h02, 32'h0000_0000);
        chk(obj_rdata, 32'h0F1F_0000);
        $display("test access done");
    endtask
    // Mask is written by the master side here; bus enable comes in on the setting inputs
    task automatic t_gp();
        out_case(32'h0000_0000, 32'h0000_0000, 8'hE4, 4'hF, 4'h0, 4'h0, 2'h0, 6'h00);
        out_case(32'h0000_0000, 32'h000F_0000, 8'hE4, 4'hF, 4'h0, 4'h0, 2'h0, 6'h0F);
        out_case(32'h0005_0000, 32'h000F_0000, 8'hE4, 4'hF, 4'h0, 4'h0, 2'h0, 6'h0A);
        out_case(32'h0005_0000, 32'h000F_0000, 8'hE4, 4'hF, 4'h3, 4'h0, 2'h0, 6'h09);
        out_case(32'h0005_0000, 32'h000F_0000, 8'hE4, 4'h7, 4'h3, 4'h0, 2'h0, 6'h01);
        out_case(32'h0005_0000, 32'h000F_0000, 8'h1B, 4'hF, 4'h0, 4'h0, 2'h0, 6'h05);
        $display("test gp outputs done");
    endtask
    task automatic t_rem();
        out_case(32'h0100_0000, 32'h0F00_0000, 8'hE4, 4'h0, 4'h0, 4'h4, 2'h3, 6'h20);
        out_case(32'h0500_0000, 32'h0F00_0000, 8'hE4, 4'h0, 4'h0, 4'h6, 2'h3, 6'h30);
        out_case(32'h0500_0000, 32'h0F00_0000, 8'hE4, 4'h0, 4'h0, 4'h6, 2'h1, 6'h10);
        out_case(32'h0500_0000, 32'h0000_0000, 8'hE4, 4'h0, 4'h0, 4'h6, 2'h3, 6'h00);
        $display("test remote outputs done");
    endtask
    // =====
    // Clock, sequence and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, obj_req, obj_wr, obj_index, obj_subindex, obj_wdata} = '0;
        {pin_cmd, alloc_lo, alloc_hi, rem_alloc, bus_lo, bus_hi, inv} = '0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_inputs();
        t_remote_in();
        t_access();
        t_gp();
        t_rem();
        finish_test();
    end
    // Whole run needs well under 500 cycles
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
